// [design/ppm_pkg.sv]
// constants and carrier types for the power management control/status block
package ppm_pkg;
  localparam logic [7:0] PPM_CSR_OFF = 8'h48;
  localparam logic [7:0] PPM_EXT_OFF = 8'h4a;
  localparam int PPM_STS_BIT = 15;
  localparam int PPM_ENB_BIT = 8;
  localparam int PPM_STATE_LSB = 0;
  localparam int PPM_STATE_MSB = 1;
  localparam int PPM_SCALE_MSB = 14;
  localparam int PPM_SELECT_LSB = 9;
  localparam int PPM_RSVD_MSB = 7;
  localparam int PPM_RSVD_LSB = 2;
  localparam logic [15:0] PPM_CSR_RESET = 16'h0000;
  localparam logic [15:0] PPM_EXT_VALUE = 16'h0000;
  localparam logic [1:0] PPM_STATE_D0 = 2'h0;
  localparam logic [1:0] PPM_STATE_D3 = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [1:0] be;
    logic [15:0] wdata;
  } ppm_cfg_req_t;
endpackage

// [design/ppm_pwr_mgmt.sv]
// power management control/status and extension registers of one function
//
// Behaviour
// R1: register untouched by D3hot-to-D0 function reset
// R2: status flag sets on every wake event
// R3: writing 1 clears status and PME; 0 ignored
// R4: data scale and select read zero
// R5: PME driven only while enable bit set
// R6: enable resets to zero; otherwise sticky
// R7: bits seven to two read zero
// R8: two-bit power state field, read/write
// R9: status, enable, state cleared by global reset only
// R10: extension register read-only, always zero
// R11: writes to read-only bits ignored
`timescale 1ns/1ns
module ppm_pwr_mgmt
  import ppm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire ppm_cfg_req_t cfg_req,
  input wire logic wake_event,
  output logic [15:0] cfg_rdata_q,
  output logic cfg_rvalid_q,
  output logic pme_out,
  output logic pme_oe_q,
  output logic [1:0] power_state_q,
  output logic d3hot_exit_rst_q
);

  // byte address bit 0 is ignored so either byte of a register hits it
  function automatic logic ppm_hit(input logic [7:0] a, input logic [7:0] off);
    ppm_hit = (a[7:1] == off[7:1]);
  endfunction

  logic sts_q;
  logic enb_q;
  logic csr_wr;
  logic ext_rd;
  logic csr_rd;
  logic sts_clr;
  logic [15:0] csr_view;
  logic sts_d;
  logic enb_d;

  assign csr_wr = cfg_req.wr && ppm_hit(cfg_req.addr, PPM_CSR_OFF);
  assign csr_rd = cfg_req.rd && ppm_hit(cfg_req.addr, PPM_CSR_OFF);
  assign ext_rd = cfg_req.rd && ppm_hit(cfg_req.addr, PPM_EXT_OFF);
  assign sts_clr = csr_wr && cfg_req.be[1] && cfg_req.wdata[PPM_STS_BIT]; // [R3]

  // data fields and reserved bits are constant zero in the read view
  always_comb begin
    csr_view = PPM_CSR_RESET; // [R4] [R7]
    csr_view[PPM_STS_BIT] = sts_q;
    csr_view[PPM_ENB_BIT] = enb_q;
    csr_view[PPM_STATE_MSB:PPM_STATE_LSB] = power_state_q;
  end

  // only the global reset reaches these; the function reset pulse below
  // is an output and never loops back here
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_q <= 1'b0; // [R9]
    end else if (wake_event) begin
      sts_q <= 1'b1; // [R2]
    end else if (sts_clr) begin
      sts_q <= 1'b0; // [R3]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enb_q <= 1'b0; // [R6] [R9]
    end else if (csr_wr && cfg_req.be[1]) begin
      enb_q <= cfg_req.wdata[PPM_ENB_BIT]; // [R11]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_state_q <= PPM_STATE_D0; // [R9]
    end else if (csr_wr && cfg_req.be[0]) begin
      power_state_q <= cfg_req.wdata[PPM_STATE_MSB:PPM_STATE_LSB]; // [R8]
    end
  end

  // the function reset is for the rest of the function; it leaves this register alone
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      d3hot_exit_rst_q <= 1'b0;
    end else begin
      d3hot_exit_rst_q <= csr_wr && cfg_req.be[0] && (power_state_q == PPM_STATE_D3)
                          && (cfg_req.wdata[PPM_STATE_MSB:PPM_STATE_LSB] == PPM_STATE_D0); // [R1]
    end
  end

  // next values of the flag and the enable, so the drive below moves in the
  // same edge as they do
  always_comb begin
    sts_d = sts_q;
    if (wake_event) begin
      sts_d = 1'b1;
    end else if (sts_clr) begin
      sts_d = 1'b0;
    end
  end

  always_comb begin
    enb_d = enb_q;
    if (csr_wr && cfg_req.be[1]) begin
      enb_d = cfg_req.wdata[PPM_ENB_BIT];
    end
  end

  // drive is the and of the next flag and enable: a cleared enable or a
  // write-1 clear never leaves the line pulled for an extra cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pme_oe_q <= 1'b0;
    end else begin
      pme_oe_q <= enb_d && sts_d; // [R5] [R3]
    end
  end

  // open-drain: the level driven is always low, only the enable moves
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pme_out <= 1'b0;
    end else begin
      pme_out <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_q <= 16'h0000;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rvalid_q <= cfg_req.rd;
      if (csr_rd) begin
        cfg_rdata_q <= csr_view;
      end else if (ext_rd) begin
        cfg_rdata_q <= PPM_EXT_VALUE; // [R10]
      end else begin
        cfg_rdata_q <= 16'h0000;
      end
    end
  end

  sequence ppm_clr_wr_s;
    sts_clr && !wake_event;
  endsequence

  sequence ppm_flag_low_s;
    !sts_q ##0 !pme_oe_q;
  endsequence

  status_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    wake_event |=> sts_q)
    else $error("status flag not set by wake event");

  status_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
    ppm_clr_wr_s |=> ppm_flag_low_s)
    else $error("write one did not clear flag and drive");

  write_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
    (sts_q && csr_wr && !cfg_req.wdata[PPM_STS_BIT]) |=> sts_q)
    else $error("write zero changed status flag");

  pme_gated_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
    pme_oe_q |-> enb_q)
    else $error("pme driven while enable was clear");

  pme_follows_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
    (enb_q && sts_q && !csr_wr) |=> pme_oe_q)
    else $error("pme not driven with enable and status set");

  csr_read_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4] [R7]
    csr_rd |=> cfg_rvalid_q && (cfg_rdata_q[PPM_SCALE_MSB:PPM_SELECT_LSB] == 6'h00)
    && (cfg_rdata_q[PPM_RSVD_MSB:PPM_RSVD_LSB] == 6'h00))
    else $error("reserved or data fields read nonzero");

  ext_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
    ext_rd |=> cfg_rvalid_q && (cfg_rdata_q == 16'h0000))
    else $error("extension register read nonzero");

  state_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
    (csr_wr && cfg_req.be[0])
    |=> power_state_q == $past(cfg_req.wdata[PPM_STATE_MSB:PPM_STATE_LSB]))
    else $error("power state not updated by write");

  state_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8] [R11]
    csr_rd |=> cfg_rdata_q[PPM_STATE_MSB:PPM_STATE_LSB] == $past(power_state_q)
    && cfg_rdata_q[PPM_ENB_BIT] == $past(enb_q))
    else $error("read back of control bits wrong");

  exit_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1] [R9]
    (d3hot_exit_rst_q && !csr_wr && !wake_event) |=> $stable({sts_q, enb_q, power_state_q}))
    else $error("function reset disturbed the register");

  // several-step behaviours are built from the sequences below
  sequence ppm_wake_s;
    wake_event;
  endsequence

  sequence ppm_set_clr_s;
    wake_event && sts_clr;
  endsequence

  sequence ppm_exit_quiet_s;
    d3hot_exit_rst_q && !csr_wr;
  endsequence

  // function reset: cause and length of the pulse, and that it leaves every field where it was
  exit_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
    d3hot_exit_rst_q
    |-> power_state_q == PPM_STATE_D0 && $past(power_state_q) == PPM_STATE_D3)
    else $error("function reset pulse without a step from D3 to D0");

  exit_once_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
    d3hot_exit_rst_q
    |=> !d3hot_exit_rst_q)
    else $error("function reset pulse longer than one cycle");

  exit_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
    d3hot_exit_rst_q
    |-> $past(csr_wr) && $past(cfg_req.be[0]))
    else $error("function reset pulse without a state write");

  exit_status_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
    ppm_exit_quiet_s ##0 sts_q
    |=> sts_q)
    else $error("function reset dropped the status flag");

  exit_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
    ppm_exit_quiet_s ##0 enb_q
    |=> enb_q)
    else $error("function reset dropped the enable bit");

  exit_state_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
    ppm_exit_quiet_s
    |=> power_state_q == PPM_STATE_D0)
    else $error("function reset moved the power state");

  // status flag: set beats clear; lanes and zero writes leave it alone
  set_wins_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    ppm_set_clr_s
    |=> sts_q)
    else $error("clear beat a wake event in the same cycle");

  set_no_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    (wake_event && !enb_q)
    |=> sts_q)
    else $error("status flag not set while enable clear");

  clear_after_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
    ppm_wake_s ##[1:8] ppm_clr_wr_s
    |=> ppm_flag_low_s)
    else $error("write one after an event left flag or drive up");

  clear_lane_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3] [R11]
    (sts_q && csr_wr && !cfg_req.be[1])
    |=> sts_q)
    else $error("status flag cleared with its byte lane off");

  status_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3] [R9]
    (!wake_event && !sts_clr)
    |=> sts_q == $past(sts_q))
    else $error("status flag moved without event or clear");

  // drive and enable
  pme_status_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3] [R5]
    pme_oe_q
    |-> sts_q)
    else $error("pme driven with status flag clear");

  pme_disable_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
    (csr_wr && cfg_req.be[1] && !cfg_req.wdata[PPM_ENB_BIT])
    |=> !pme_oe_q)
    else $error("pme still driven after enable cleared");

  wake_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2] [R5]
    (wake_event && enb_q && !(csr_wr && cfg_req.be[1]))
    |=> pme_oe_q)
    else $error("pme not driven after enabled wake event");

  enable_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
    (csr_wr && cfg_req.be[1])
    |=> enb_q == $past(cfg_req.wdata[PPM_ENB_BIT]))
    else $error("enable bit not taken from write");

  enable_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6] [R9]
    !(csr_wr && cfg_req.be[1])
    |=> enb_q == $past(enb_q))
    else $error("enable bit moved without a write");

  // power state and read-only space
  state_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8] [R9]
    !(csr_wr && cfg_req.be[0])
    |=> power_state_q == $past(power_state_q))
    else $error("power state moved without a write");

  csr_word_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4] [R7] [R8]
    csr_rd
    |=> cfg_rdata_q == {$past(sts_q), 6'h00, $past(enb_q), 6'h00, $past(power_state_q)})
    else $error("control and status read word wrong");

  ext_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10] [R11]
    (cfg_req.wr && ppm_hit(cfg_req.addr, PPM_EXT_OFF))
    |=> enb_q == $past(enb_q) && power_state_q == $past(power_state_q))
    else $error("extension write changed the control register");

endmodule

// [verif/ppm_host_pme.sv]
// host side view of the open-drain wake line
`timescale 1ns/1ns
module ppm_host_pme (
  input wire logic pme_out,
  input wire logic pme_oe_q,
  output wire logic pme_n
);
  // pull-up wins whenever the block releases the line
  assign pme_n = pme_oe_q ? pme_out : 1'b1;
endmodule

// [verif/ppm_pwr_mgmt_tb.sv]
// testbench for the power management register block
`timescale 1ns/1ns
module ppm_pwr_mgmt_tb;
  import ppm_pkg::*;
  logic ref_clk = 0, rst_n = 0, wake_event = 0, seen = 0;
  ppm_cfg_req_t cfg_req = '0;
  logic [15:0] cfg_rdata_q;
  logic cfg_rvalid_q, pme_out, pme_oe_q, d3hot_exit_rst_q, pme_n;
  logic [1:0] power_state_q;
  int num_errors = 0, comparisons = 0, cycles = 0;
  always #25 ref_clk = ~ref_clk;
  ppm_pwr_mgmt i_ppm_pwr_mgmt (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_req(cfg_req),
    .wake_event(wake_event), .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
    .pme_out(pme_out), .pme_oe_q(pme_oe_q), .power_state_q(power_state_q),
    .d3hot_exit_rst_q(d3hot_exit_rst_q));
  ppm_host_pme i_ppm_host_pme (.pme_out(pme_out), .pme_oe_q(pme_oe_q), .pme_n(pme_n));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask
  // one idle cycle after each access keeps strobes from being set twice in a step
  task automatic acc(logic [7:0] a, logic w, logic [1:0] be, logic [15:0] d);
    cfg_req = '{a, w, ~w, be, d};
    @(posedge ref_clk) #1;
    cfg_req = '0;
    seen = d3hot_exit_rst_q;
    if (!w) chk("rvalid", 16'h0001, {15'h0, cfg_rvalid_q});
    if (!w) chk("rdata", d, cfg_rdata_q);
    @(posedge ref_clk) #1;
  endtask
  task automatic wake;
    wake_event = 1'b1;
    @(posedge ref_clk) #1;
    wake_event = 1'b0;
    @(posedge ref_clk) #1;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    @(posedge ref_clk) #1;
    acc(PPM_CSR_OFF, 0, 2'h0, 16'h0000);
    acc(PPM_EXT_OFF, 1, 2'h3, 16'hffff);
    acc(PPM_EXT_OFF, 0, 2'h0, PPM_EXT_VALUE);
    acc(PPM_CSR_OFF, 1, 2'h3, 16'hffff);
    acc(PPM_CSR_OFF, 0, 2'h0, 16'h0103);
    for (int s = 0; s < 4; s++) begin
      acc(PPM_CSR_OFF, 1, 2'h1, 16'(s));
      chk("d3 exit", {15'h0, s == 0}, {15'h0, seen});
      chk("state", 16'(s), {14'h0, power_state_q});
      acc(PPM_CSR_OFF, 0, 2'h0, 16'h0100 | 16'(s));
    end
    $display("register test done");
    wake();
    chk("pme", 16'h0000, {15'h0, pme_n});
    acc(PPM_CSR_OFF, 1, 2'h2, 16'h0100);
    acc(PPM_CSR_OFF, 0, 2'h0, 16'h8103);
    acc(PPM_CSR_OFF, 1, 2'h0, 16'h8000);
    acc(PPM_CSR_OFF, 0, 2'h0, 16'h8103);
    acc(PPM_CSR_OFF, 1, 2'h2, 16'h8100);
    chk("pme", 16'h0001, {15'h0, pme_n});
    acc(PPM_CSR_OFF, 1, 2'h2, 16'h0000);
    wake();
    chk("pme", 16'h0001, {15'h0, pme_n});
    acc(PPM_CSR_OFF, 0, 2'h0, 16'h8003);
    // event and write-1 clear in the same edge: the event wins
    wake_event = 1'b1;
    cfg_req = '{PPM_CSR_OFF, 1'b1, 1'b0, 2'h2, 16'h8000};
    @(posedge ref_clk) #1;
    wake_event = 1'b0;
    cfg_req = '0;
    @(posedge ref_clk) #1;
    acc(PPM_CSR_OFF, 0, 2'h0, 16'h8003);
    acc(PPM_CSR_OFF, 1, 2'h1, 16'h0000);
    chk("d3 exit", 16'h0001, {15'h0, seen});
    acc(PPM_CSR_OFF, 0, 2'h0, 16'h8000);
    $display("wake test done");
    rst_n = 1'b0;
    @(posedge ref_clk) #1 rst_n = 1'b1;
    @(posedge ref_clk) #1;
    acc(PPM_CSR_OFF, 0, 2'h0, 16'h0000);
    $display("reset test done");
    give_verdict();
  end
endmodule
